// [dv/adc_calibration_control_asserts.sv]
// Purpose: port-level checks for calibration control
// Assumes: one clock, sync active-low reset
// Notes: bound to the top design module
`default_nettype none
module adc_cal_ctrl_checker (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic results_clear, // clear pulse
    input wire logic linearity_active, // linearity phase
    input wire logic offset_active, // offset phase
    input wire logic offset_reference_spare, // spare target
    input wire logic [2:0] active_depth // phase depth
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_aw_reopen: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_awready ##1 s_axi_awready)
        else $error("write address ready timing wrong");
    a_b_after_take: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
        else $error("write response before both taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while pending");
    a_clear_pulse: assert property (results_clear |-> !linearity_active && !offset_active ##1 !results_clear)
        else $error("result clear not a lone pulse");
    a_spare_offset: assert property (offset_reference_spare |-> offset_active)
        else $error("spare target outside offset phase");
    a_phase_excl: assert property (linearity_active |-> !offset_active)
        else $error("two phases at once");
    a_depth_steady: assert property (linearity_active && $past(linearity_active) |-> $stable(active_depth))
        else $error("depth moved inside a phase");
    cover property (offset_reference_spare);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (results_clear);
endmodule
bind adc_calibration_control adc_cal_ctrl_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .results_clear(results_clear), .linearity_active(linearity_active),
    .offset_active(offset_active), .offset_reference_spare(offset_reference_spare),
    .active_depth(active_depth));
`default_nettype wire

// [dv/test_adc_calibration_control.sv]
// Purpose: self-checking bench for calibration control
// Assumes: byte address is four times the register index
// Notes: small averaging depths keep phases short
`default_nettype none
`include "adc_cal_regs.vh"
module test_adc_calibration_control;
timeunit 1ns;
timeprecision 1ps;
logic aclk = 0;
logic aresetn = 0;
logic [9:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hw_trig = 0;
logic awready, wready, bvalid, arready, rvalid, rclr, lin, off, spare, irq;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [2:0] depth;
int error_cnt = 0, samples_checked = 0, clear_cnt = 0;
always #4 aclk = ~aclk;
always @(posedge aclk) if (rclr) clear_cnt <= clear_cnt + 1;
adc_calibration_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hardware_trigger_input(hw_trig), .results_clear(rclr), .linearity_active(lin),
    .offset_active(off), .offset_reference_spare(spare), .active_depth(depth), .irq(irq));
task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        error_cnt++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task give_up;
    chk(32'h0000_0001, 32'h0000_0000);
    tally_and_finish;
endtask
task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) give_up;
    chk(bresp, er);
endtask
task rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) give_up;
endtask
task rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, exp);
    chk(r, `RESP_OKAY);
endtask
task poll(input logic [7:0] mask, input logic [7:0] want, output logic [31:0] d);
    int n;
    logic [1:0] r;
    for (n = 0; n < 300; n++) begin
        rd(`IDX_CAL_STATE, d, r);
        if ((d[7:0] & mask) === want) break;
    end
    if (n == 300) give_up;
endtask
task wait_hi(input int which);
    int n;
    for (n = 0; n < 800 && !(which ? off : lin); n++) @(posedge aclk);
    if (n == 800) give_up;
endtask
// hold calibration, program it, then release; mode, offset and averaging settings are written while held
task setup(input logic [7:0] mode, input logic [7:0] oref, input logic [7:0] avg);
    int c;
    wr(`IDX_CAL_ENABLE, 8'h00, `RESP_OKAY);
    wr(`IDX_CAL_STATE, 8'hff, `RESP_OKAY);
    rdc(`IDX_CAL_STATE, 8'h00);
    wr(`IDX_MODE_SELECT, mode, `RESP_OKAY);
    wr(`IDX_OFFSET_REF, oref, `RESP_OKAY);
    wr(`IDX_AVG_DEPTH, avg, `RESP_OKAY);
    c = clear_cnt;
    wr(`IDX_CAL_ENABLE, 8'h01, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(clear_cnt - c, 1);
endtask
task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdc(`IDX_CAL_ENABLE, 8'h01);
    rdc(`IDX_MODE_SELECT, 8'h01);
    rdc(`IDX_OFFSET_REF, 8'h01);
    rdc(`IDX_AVG_DEPTH, 8'h61);
    rdc(`IDX_TRIG_CFG, 8'h00);
    rdc(`IDX_SOFT_TRIG, 8'h01);
    rdc(`IDX_IRQ_MASK, 8'h00);
    wr(8'h7f, 8'h01, `RESP_SLVERR);
    rd(8'h7f, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, 0);
    $display("reset values and map done");
endtask
task t_fg_offset;
    logic [31:0] d;
    setup(8'h05, 8'h01, 8'h40);
    wait_hi(1);
    chk(off, 1'b1);
    chk(spare, 1'b0);
    chk(depth, 3'h4);
    poll(8'h01, 8'h01, d);
    chk(d, 8'h1f);
    $display("foreground with offset done");
endtask
task t_fg_skip;
    logic [31:0] d;
    logic seen;
    wr(`IDX_SOFT_TRIG, 8'h00, `RESP_OKAY);
    setup(8'h00, 8'h01, 8'h00);
    rdc(`IDX_CAL_STATE, 8'h04);
    wr(`IDX_SOFT_TRIG, 8'h01, `RESP_OKAY);
    seen = 0;
    repeat (40) begin
        @(posedge aclk);
        seen |= lin;
    end
    poll(8'h01, 8'h01, d);
    chk(seen, 1'b0);
    chk(d, 8'h1f);
    $display("foreground skip done");
endtask
task t_bg_halt;
    logic [31:0] d;
    logic [1:0] r;
    rd(`IDX_IRQ_STATUS, d, r);
    setup(8'h0a, 8'h05, 8'h32);
    wait_hi(0);
    chk(depth, 3'h2);
    wait_hi(1);
    chk(spare, 1'b1);
    chk(depth, 3'h3);
    wr(`IDX_TRIG_CFG, 8'h01, `RESP_OKAY);
    poll(8'h02, 8'h02, d);
    chk(d, 8'h1b);
    chk(irq, 1'b0);
    wr(`IDX_IRQ_MASK, 8'h03, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    rdc(`IDX_IRQ_STATUS, 8'h03);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    hw_trig <= 1'b1;
    poll(8'h02, 8'h00, d);
    chk(d[1:0], 2'h1);
    $display("background halt and resume done");
endtask
initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_fg_offset;
    t_fg_skip;
    t_bg_halt;
    tally_and_finish;
end
endmodule
`default_nettype wire

// [hw/adc_cal_regs.vh]
// Purpose: register indices, field positions, reset values and timing for calibration control
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef ADC_CAL_REGS_VH
`define ADC_CAL_REGS_VH

`define IDX_CAL_ENABLE 8'h61
`define IDX_MODE_SELECT 8'h62
`define IDX_OFFSET_REF 8'h65
`define IDX_AVG_DEPTH 8'h68
`define IDX_CAL_STATE 8'h6a
`define IDX_TRIG_CFG 8'h6b
`define IDX_SOFT_TRIG 8'h6c
`define IDX_IRQ_STATUS 8'h70
`define IDX_IRQ_MASK 8'h71

`define RST_CAL_ENABLE 8'h01
`define RST_MODE_SELECT 8'h01
`define RST_OFFSET_REF 8'h01
`define RST_AVG_DEPTH 8'h61
`define RST_TRIG_CFG 8'h00
`define RST_SOFT_TRIG 8'h01

`define BIT_FG_SELECT 0
`define BIT_BG_ENABLE 1
`define BIT_FG_OFFSET 2
`define BIT_BG_OFFSET 3
`define BIT_OFFSET_REF 2
`define BIT_TRIG_SOURCE 0
`define BIT_SOFT_TRIG 0
`define BIT_FOREGROUND_COMPLETE_FLAG 0
`define BIT_BG_HALTED 1
`define FLD_STATE_LSB 2
`define FLD_OFFSET_AVERAGING_DEPTH_LSB 4
`define FLD_LIN_AVG_LSB 0

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// base length of one averaging step, in ns; doubled per depth step
`define CAL_STEP_NS 128
`define CLK_PERIOD_NS 8
`define CAL_STEP_CYCLES (`CAL_STEP_NS / `CLK_PERIOD_NS)

`endif

// [hw/adc_calibration_control.v]
// Purpose: configuration, sequencing and status of the converter calibration engine
// Assumes: AXI4-Lite slave, one outstanding write and one read; byte address = 4 * index
// Notes: reading the interrupt status register clears it
// Behaviour
// - foreground select 0 clears results and skips; 1 clears then runs foreground
// - background calibration runs only while background enable bit 1 is set
// - bit 2 enables foreground offset step, only together with foreground select
// - bit 3 enables background offset step, only together with background enable
// - offset reference 0 targets mid-code, zero offset
// - offset reference 1 matches primaries to the substituting spare converter
// - bits 6:4 of averaging register set offset averaging, reset 6
// - bits 2:0 of averaging register set linearity averaging, reset 1
// - halted flag reads 1 once background stops at requested phase
// - halted flag returns to 0 when calibration resumes
// - with background off, halted flag sets when foreground finishes or skips
// - status bit 0 foreground complete; bits 4:2 hold state code
// - global enable low holds calibration in reset; high starts it
// - trigger source 1 uses hardware trigger input, ignores software trigger
`default_nettype none
`include "adc_cal_regs.vh"
module adc_calibration_control #(
    parameter TIMER_WIDTH = 16
) (
    input wire aclk,                    // clock, 125 MHz
    input wire aresetn,                 // sync reset, active low
    input wire [9:0] s_axi_awaddr,      // write address
    input wire [2:0] s_axi_awprot,      // unused
    input wire s_axi_awvalid,           // write address valid
    output reg s_axi_awready,           // write address ready
    input wire [31:0] s_axi_wdata,      // write data
    input wire [3:0] s_axi_wstrb,       // byte enables
    input wire s_axi_wvalid,            // write data valid
    output reg s_axi_wready,            // write data ready
    output reg [1:0] s_axi_bresp,       // write response
    output reg s_axi_bvalid,            // write response valid
    input wire s_axi_bready,            // write response ready
    input wire [9:0] s_axi_araddr,      // read address
    input wire [2:0] s_axi_arprot,      // unused
    input wire s_axi_arvalid,           // read address valid
    output reg s_axi_arready,           // read address ready
    output reg [31:0] s_axi_rdata,      // read data
    output reg [1:0] s_axi_rresp,       // read response
    output reg s_axi_rvalid,            // read data valid
    input wire s_axi_rready,            // read data ready
    input wire hardware_trigger_input,  // calibration trigger pin
    output reg results_clear,           // pulse: clear calibration results
    output reg linearity_active,        // linearity phase running
    output reg offset_active,           // offset phase running
    output reg offset_reference_spare,  // offset target: spare converter
    output reg [2:0] active_depth,      // averaging depth of current phase
    output reg irq                      // level interrupt
);
    localparam ST_HELD = 3'd0;
    localparam ST_WAIT_TRIG = 3'd1;
    localparam ST_FG_LIN = 3'd2;
    localparam ST_FG_OS = 3'd3;
    localparam ST_BG_LIN = 3'd4;
    localparam ST_BG_OS = 3'd5;
    localparam ST_BG_HALT = 3'd6;
    localparam ST_DONE = 3'd7;

    reg cal_enable;
    reg foreground_run_select;
    reg background_run_enable;
    reg foreground_offset_enable;
    reg background_offset_enable;
    reg offset_reference_select;
    reg [2:0] offset_averaging_depth;
    reg [2:0] linearity_averaging_depth;
    reg trigger_source_select;
    reg software_trigger_bit;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [2:0] state;
    reg foreground_complete_flag;
    reg background_halted_flag;
    reg [7:0] aw_index;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg aw_held;
    reg w_held;
    reg [2:0] next_state;
    reg next_start;

    wire phase_done;
    wire trigger = trigger_source_select ? hardware_trigger_input : software_trigger_bit;
    wire [7:0] ar_index = s_axi_araddr[9:2];
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire bg_on = background_run_enable;
    wire fg_os_on = foreground_offset_enable && foreground_run_select;
    wire bg_os_on = background_offset_enable && background_run_enable;

    function mapped;
        input [7:0] idx;
        begin
            mapped = (idx == `IDX_CAL_ENABLE) || (idx == `IDX_MODE_SELECT) || (idx == `IDX_OFFSET_REF) ||
                (idx == `IDX_AVG_DEPTH) || (idx == `IDX_CAL_STATE) || (idx == `IDX_TRIG_CFG) ||
                (idx == `IDX_SOFT_TRIG) || (idx == `IDX_IRQ_STATUS) || (idx == `IDX_IRQ_MASK);
        end
    endfunction

    function is_offset_state;
        input [2:0] st;
        begin
            is_offset_state = (st == ST_FG_OS) || (st == ST_BG_OS);
        end
    endfunction

    cal_phase_timer #(
        .WIDTH(TIMER_WIDTH),
        .BASE_CYCLES(`CAL_STEP_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .abort(!cal_enable),
        .start(next_start),
        .depth(is_offset_state(next_state) ? offset_averaging_depth : linearity_averaging_depth),
        .done(phase_done)
    );

    // sequencing of the calibration phases
    always @* begin
        next_state = state;
        next_start = 1'b0;
        if (!cal_enable) begin
            next_state = ST_HELD;
        end else begin
            case (state)
                ST_HELD: begin
                    next_state = ST_WAIT_TRIG;
                end
                ST_WAIT_TRIG: begin
                    if (trigger) begin
                        if (foreground_run_select) begin
                            next_state = ST_FG_LIN;
                        end else if (bg_on) begin
                            next_state = ST_BG_LIN;
                        end else begin
                            next_state = ST_DONE;
                        end
                    end
                end
                ST_FG_LIN: begin
                    if (phase_done) begin
                        next_state = fg_os_on ? ST_FG_OS : (bg_on ? ST_BG_LIN : ST_DONE);
                    end
                end
                ST_FG_OS: begin
                    if (phase_done) begin
                        next_state = bg_on ? ST_BG_LIN : ST_DONE;
                    end
                end
                ST_BG_LIN, ST_BG_OS: begin
                    if (phase_done) begin
                        if (!bg_on) begin
                            next_state = ST_DONE;
                        end else if (!trigger) begin
                            next_state = ST_BG_HALT;
                        end else if (state == ST_BG_LIN && bg_os_on) begin
                            next_state = ST_BG_OS;
                        end else begin
                            next_state = ST_BG_LIN;
                        end
                    end
                end
                ST_BG_HALT: begin
                    if (!bg_on) begin
                        next_state = ST_DONE;
                    end else if (trigger) begin
                        next_state = ST_BG_LIN;
                    end
                end
                ST_DONE: begin
                    if (bg_on && trigger) begin
                        next_state = ST_BG_LIN;
                    end
                end
                default: begin
                    next_state = ST_HELD;
                end
            endcase
            if (next_state != state || phase_done) begin
                next_start = (next_state >= ST_FG_LIN) && (next_state <= ST_BG_OS);
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_HELD;
            results_clear <= 1'b0;
            linearity_active <= 1'b0;
            offset_active <= 1'b0;
            offset_reference_spare <= 1'b0;
            active_depth <= 3'd0;
            foreground_complete_flag <= 1'b0;
            background_halted_flag <= 1'b0;
        end else begin
            state <= next_state;
            // results cleared on every start, whether foreground runs or not
            results_clear <= (state == ST_HELD) && cal_enable;
            linearity_active <= (next_state == ST_FG_LIN) || (next_state == ST_BG_LIN);
            offset_active <= is_offset_state(next_state);
            offset_reference_spare <= is_offset_state(next_state) && offset_reference_select;
            active_depth <= is_offset_state(next_state) ? offset_averaging_depth : linearity_averaging_depth;
            if (!cal_enable) begin
                foreground_complete_flag <= 1'b0;
                background_halted_flag <= 1'b0;
            end else begin
                if (next_state != ST_WAIT_TRIG && (state == ST_WAIT_TRIG || state == ST_FG_LIN ||
                        state == ST_FG_OS) && next_state != ST_FG_LIN && next_state != ST_FG_OS) begin
                    foreground_complete_flag <= 1'b1;
                end
                if (next_state == ST_BG_HALT || next_state == ST_DONE) begin
                    background_halted_flag <= 1'b1;
                end else if (state == ST_BG_HALT || state == ST_DONE) begin
                    background_halted_flag <= 1'b0;
                end
            end
        end
    end

    // write channel: address and data taken in either order, answer one cycle after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_index <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            cal_enable <= |(`RST_CAL_ENABLE & 8'h01);
            foreground_run_select <= |((`RST_MODE_SELECT >> `BIT_FG_SELECT) & 8'h01);
            background_run_enable <= 1'b0;
            foreground_offset_enable <= 1'b0;
            background_offset_enable <= 1'b0;
            offset_reference_select <= 1'b0;
            offset_averaging_depth <= 3'h6;
            linearity_averaging_depth <= 3'h1;
            trigger_source_select <= 1'b0;
            software_trigger_bit <= 1'b1;
            irq_mask <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !do_write;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !do_write;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_index <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_index) ? `RESP_OKAY : `RESP_SLVERR;
                // reserved bits are not stored; software keeps them at reset values
                if (w_strb[0]) begin
                    case (aw_index)
                        `IDX_CAL_ENABLE: cal_enable <= w_data[0];
                        `IDX_MODE_SELECT: begin
                            foreground_run_select <= w_data[`BIT_FG_SELECT];
                            background_run_enable <= w_data[`BIT_BG_ENABLE];
                            foreground_offset_enable <= w_data[`BIT_FG_OFFSET];
                            background_offset_enable <= w_data[`BIT_BG_OFFSET];
                        end
                        `IDX_OFFSET_REF: offset_reference_select <= w_data[`BIT_OFFSET_REF];
                        `IDX_AVG_DEPTH: begin
                            offset_averaging_depth <= w_data[`FLD_OFFSET_AVERAGING_DEPTH_LSB +: 3];
                            linearity_averaging_depth <= w_data[`FLD_LIN_AVG_LSB +: 3];
                        end
                        `IDX_TRIG_CFG: trigger_source_select <= w_data[`BIT_TRIG_SOURCE];
                        `IDX_SOFT_TRIG: software_trigger_bit <= w_data[`BIT_SOFT_TRIG];
                        `IDX_IRQ_MASK: irq_mask <= w_data[1:0];
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // read channel; interrupt status clears on read, a new event in that cycle survives
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
            irq_status <= 2'b00;
            irq <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(ar_index) ? `RESP_OKAY : `RESP_SLVERR;
                case (ar_index)
                    `IDX_CAL_ENABLE: s_axi_rdata <= {31'h0000_0000, cal_enable};
                    `IDX_MODE_SELECT: s_axi_rdata <= {28'h000_0000, background_offset_enable,
                        foreground_offset_enable, background_run_enable, foreground_run_select};
                    `IDX_OFFSET_REF: s_axi_rdata <= {29'h0000_0000, offset_reference_select, 2'b01};
                    `IDX_AVG_DEPTH: s_axi_rdata <= {25'h000_0000, offset_averaging_depth, 1'b0,
                        linearity_averaging_depth};
                    `IDX_CAL_STATE: s_axi_rdata <= {27'h000_0000, state, background_halted_flag,
                        foreground_complete_flag};
                    `IDX_TRIG_CFG: s_axi_rdata <= {31'h0000_0000, trigger_source_select};
                    `IDX_SOFT_TRIG: s_axi_rdata <= {31'h0000_0000, software_trigger_bit};
                    `IDX_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status};
                    `IDX_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            irq_status <= (ar_take && ar_index == `IDX_IRQ_STATUS ? 2'b00 : irq_status) |
                {background_halted_flag == 1'b0 && (next_state == ST_BG_HALT || next_state == ST_DONE)
                    && cal_enable,
                 foreground_complete_flag == 1'b0 && cal_enable && state != ST_HELD &&
                    (state == ST_WAIT_TRIG || state == ST_FG_LIN || state == ST_FG_OS) &&
                    next_state != ST_WAIT_TRIG && next_state != ST_FG_LIN && next_state != ST_FG_OS};
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule
`default_nettype wire

// [hw/cal_phase_timer.v]
// Purpose: times one calibration phase, length grows with averaging depth
// Assumes: start is a one-cycle pulse; abort wins over start
// Notes: done is a registered one-cycle pulse
`default_nettype none
module cal_phase_timer #(
    parameter WIDTH = 16,
    parameter BASE_CYCLES = 16
) (
    input wire aclk,             // clock
    input wire aresetn,          // sync reset, active low
    input wire abort,            // stop counting at once
    input wire start,            // begin a phase
    input wire [2:0] depth,      // averaging depth
    output reg done              // phase finished
);
    reg [WIDTH-1:0] remaining;
    reg running;
    wire [WIDTH-1:0] base_len = BASE_CYCLES[WIDTH-1:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            remaining <= {WIDTH{1'b0}};
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                remaining <= (base_len << depth) - {{(WIDTH-1){1'b0}}, 1'b1};
                running <= 1'b1;
            end else if (running) begin
                if (remaining == {WIDTH{1'b0}}) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire
